// ===== core/battery_meas_pkg.sv
// shared constants and types for the battery measurement result block
package battery_meas_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 100;
	localparam int SAMPLE_PERIOD_NS = 687000;
	localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int VOLT_SLOT_A      = 0;
	localparam int VOLT_SLOT_B      = 5;
	localparam int TEMP_SLOT        = 2;
	localparam int SLOTS            = 10;
	// ----------------------------------------------------------------
	// averaging depths, as shift counts
	// ----------------------------------------------------------------
	localparam int INST_SHIFT = 7;
	localparam int AVG_SHIFT  = 12;
	localparam int AVG_EXTRA  = 3;
	localparam int VOLT_SHIFT = 2;
	localparam int TEMP_SHIFT = 5;
	localparam int ACC_SHIFT  = 16;
	localparam logic signed [16:0] BLANK_LIMIT = 17'sd64;
	// ----------------------------------------------------------------
	// word addresses and configuration fields
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_AUX_RATIO = 16'h6000;
	localparam logic [15:0] ADDR_AUX_ABS   = 16'h6001;
	localparam logic [15:0] ADDR_UPPER     = 16'h6002;
	localparam logic [15:0] ADDR_LOWER     = 16'h6003;
	localparam logic [15:0] ADDR_INSTANT   = 16'h6004;
	localparam logic [15:0] ADDR_TEMP      = 16'h6005;
	localparam logic [15:0] ADDR_ACC_MAIN  = 16'h6006;
	localparam logic [15:0] ADDR_ACC_MID   = 16'h6007;
	localparam logic [15:0] ADDR_ACC_LOW   = 16'h6008;
	localparam logic [15:0] ADDR_AVERAGE   = 16'h6009;
	localparam logic [15:0] ADDR_CONFIG    = 16'h600a;
	localparam int CFG_BIAS_MSB  = 15;
	localparam int CFG_BIAS_LSB  = 8;
	localparam int CFG_BLANK_BIT = 0;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [15:0] POS_LIMIT    = 16'h7fff;
	localparam logic [15:0] NEG_LIMIT    = 16'h8000;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CH_CURRENT   = 3'b000,
		CH_LOWER     = 3'b001,
		CH_UPPER     = 3'b010,
		CH_AUX_ABS   = 3'b011,
		CH_AUX_RATIO = 3'b100,
		CH_TEMP      = 3'b101
	} conv_chan_t;
	typedef struct packed {
		logic        valid;
		conv_chan_t  chan;
	} conv_req_t;
	typedef struct packed {
		logic        valid;
		conv_chan_t  chan;
		logic [15:0] data;
	} conv_result_t;
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_req_t;
endpackage : battery_meas_pkg

// ===== core/battery_measurement_results.sv
// measurement sequencer, averaging, charge accumulator and result words
// Operation
// - one current sample every sample period
// - voltage sample every five sample periods
// - temperature every ten periods, averaged before update
// - average voltage samples per result word
// - auxiliary reported absolute and as supply ratio
// - results as consecutive words from 6000h
// - instant current averages 128 samples
// - positive result means charging current
// - instant current clamps at 7fffh and 8000h
// - average of 4096 samples, three extra bits
// - continuous offset cancellation by rounded averages
// - signed bias added to every current sample
// - bias sits in configuration upper byte
// - 16-bit signed charge accumulator word
// - accumulator saturates at both extremes
// - software reads and writes main accumulator
// - 32 fraction bits in two extra words
// - main word write clears fraction words
// - blanking drops small positive samples from the accumulator
// - cell voltage words clamp at maximum
// - temperature word two's complement, averaged
// - bias 15:8, reserved 7:1, blank bit 0
// - auxiliary words unsigned averages clamped at 7fffh, absolute and ratio form
`timescale 1ns/100ps
module battery_measurement_results
	import battery_meas_pkg::*;
#(
	parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_reset_n,
	input  wire mem_req_t     i_mem,
	output logic [15:0]       o_rdata,
	output conv_req_t         o_conv_req,
	input  wire conv_result_t i_conv
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sd32767) begin
			sat16 = POS_LIMIT;
		end else if (v < -32'sd32768) begin
			sat16 = NEG_LIMIT;
		end else begin
			sat16 = v[15:0];
		end
	endfunction : sat16

	// rounding by half an lsb keeps the residual offset within half a step
	function automatic logic signed [31:0] rshift_round(input logic signed [31:0] v,
		input int sh);
		logic signed [31:0] half;
		half = 32'sd1 <<< (sh - 1);
		rshift_round = (v + half) >>> sh;
	endfunction : rshift_round

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [12:0]        period_cnt, next_period_cnt;
	logic [3:0]         slot, next_slot;
	logic [1:0]         volt_sel, next_volt_sel;
	conv_req_t          next_conv_req;
	logic [15:0]        config_word, next_config_word;
	logic [15:0]        result [4], next_result [4];
	logic [17:0]        vsum [4], next_vsum [4];
	logic [1:0]         vcnt [4], next_vcnt [4];
	logic [15:0]        temperature_result, next_temperature_result;
	logic signed [20:0] tsum, next_tsum;
	logic [4:0]         tcnt, next_tcnt;
	logic [15:0]        instant_current, next_instant_current;
	logic signed [23:0] isum, next_isum;
	logic [6:0]         icnt, next_icnt;
	logic [15:0]        average_current, next_average_current;
	logic signed [28:0] asum, next_asum;
	logic [11:0]        acnt, next_acnt;
	logic signed [47:0] charge_accumulator, next_charge_accumulator;
	logic [15:0]        next_rdata;
	logic signed [16:0] corrected;
	logic               cur_valid;
	logic               blanked;
	logic signed [48:0] acc_sum;
	logic signed [31:0] inst_calc;

	// ----------------------------------------------------------------
	// current sample path
	// ----------------------------------------------------------------
	assign cur_valid = i_conv.valid && (i_conv.chan == CH_CURRENT);
	// bias per sample
	// a positive raw sample is charge, and the sign is kept end to end
	assign corrected = 17'($signed(i_conv.data)) +
		17'($signed(config_word[CFG_BIAS_MSB:CFG_BIAS_LSB]));
	assign blanked = config_word[CFG_BLANK_BIT] && (corrected > 17'sd0) &&
		(corrected < BLANK_LIMIT);
	assign acc_sum = 49'(charge_accumulator) + (49'(corrected) <<< ACC_SHIFT);
	assign inst_calc = rshift_round(32'(isum + 24'(corrected)), INST_SHIFT);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_period_cnt         = period_cnt;
		next_slot               = slot;
		next_volt_sel           = volt_sel;
		next_conv_req           = '0;
		next_config_word        = config_word;
		next_result             = result;
		next_vsum               = vsum;
		next_vcnt               = vcnt;
		next_temperature_result = temperature_result;
		next_tsum               = tsum;
		next_tcnt               = tcnt;
		next_instant_current    = instant_current;
		next_isum               = isum;
		next_icnt               = icnt;
		next_average_current    = average_current;
		next_asum               = asum;
		next_acnt               = acnt;
		next_charge_accumulator = charge_accumulator;
		next_rdata              = o_rdata;

		if (32'(period_cnt) == SAMPLE_PERIOD - 1) begin
			next_period_cnt = '0;
			next_slot = (32'(slot) == SLOTS - 1) ? 4'h0 : slot + 4'h1;
		end else begin
			next_period_cnt = period_cnt + 13'h1;
		end
		if (period_cnt == 13'h0) begin
			next_conv_req = '{valid: 1'b1, chan: CH_CURRENT};
		end else if (32'(period_cnt) == SAMPLE_PERIOD / 2) begin
			// voltage slots rotate through four words
			if (32'(slot) == VOLT_SLOT_A || 32'(slot) == VOLT_SLOT_B) begin
				next_conv_req = '{valid: 1'b1, chan: conv_chan_t'(3'(volt_sel) + 3'h1)};
				next_volt_sel = volt_sel + 2'h1;
			end else if (32'(slot) == TEMP_SLOT) begin
				next_conv_req = '{valid: 1'b1, chan: CH_TEMP};
			end
		end

		for (int i = 0; i < 4; i++) begin
			if (i_conv.valid && (32'(i_conv.chan) == i + 1)) begin
				if (vcnt[i] == 2'h3) begin
					next_result[i] = sat16(32'(vsum[i] + 18'(i_conv.data)) >>> VOLT_SHIFT);
					next_vsum[i] = '0;
				end else begin
					next_vsum[i] = vsum[i] + 18'(i_conv.data);
				end
				next_vcnt[i] = vcnt[i] + 2'h1;
			end
		end

		if (i_conv.valid && i_conv.chan == CH_TEMP) begin
			if (tcnt == 5'h1f) begin
				next_temperature_result = sat16(rshift_round(
					32'(tsum + 21'($signed(i_conv.data))), TEMP_SHIFT));
				next_tsum = '0;
			end else begin
				next_tsum = tsum + 21'($signed(i_conv.data));
			end
			next_tcnt = tcnt + 5'h1;
		end

		if (cur_valid) begin
			if (icnt == 7'h7f) begin
				next_instant_current = sat16(inst_calc);
				next_isum = '0;
			end else begin
				next_isum = isum + 24'(corrected);
			end
			next_icnt = icnt + 7'h1;
			// long average keeps three more bits
			if (acnt == 12'hfff) begin
				next_average_current = sat16(rshift_round(
					32'(asum + 29'(corrected)), AVG_SHIFT - AVG_EXTRA));
				next_asum = '0;
			end else begin
				next_asum = asum + 29'(corrected);
			end
			next_acnt = acnt + 12'h1;
			if (!blanked) begin
				if (acc_sum[48] != acc_sum[47]) begin
					next_charge_accumulator = acc_sum[48] ?
						{1'b1, 47'h0} : {1'b0, {47{1'b1}}};
				end else begin
					next_charge_accumulator = acc_sum[47:0];
				end
			end
		end

		// software writes win over a sample in the same cycle
		if (i_mem.wr) begin
			if (i_mem.addr == ADDR_ACC_MAIN) begin
				next_charge_accumulator = {i_mem.wdata, 32'h0};
			end
			if (i_mem.addr == ADDR_CONFIG) begin
				next_config_word = {i_mem.wdata[CFG_BIAS_MSB:CFG_BIAS_LSB], 7'h0,
					i_mem.wdata[CFG_BLANK_BIT]};
			end
		end

		// one word per access: a sample may land between two accumulator reads
		// word map
		if (i_mem.rd) begin
			unique case (i_mem.addr)
				ADDR_AUX_RATIO: next_rdata = result[3];
				ADDR_AUX_ABS:   next_rdata = result[2];
				ADDR_UPPER:     next_rdata = result[1];
				ADDR_LOWER:     next_rdata = result[0];
				ADDR_INSTANT:   next_rdata = instant_current;
				ADDR_TEMP:      next_rdata = temperature_result;
				ADDR_ACC_MAIN:  next_rdata = charge_accumulator[47:32];
				ADDR_ACC_MID:   next_rdata = charge_accumulator[31:16];
				ADDR_ACC_LOW:   next_rdata = charge_accumulator[15:0];
				ADDR_AVERAGE:   next_rdata = average_current;
				ADDR_CONFIG:    next_rdata = config_word;
				default:        next_rdata = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			period_cnt         <= '0;
			slot               <= '0;
			volt_sel           <= '0;
			o_conv_req         <= '0;
			config_word        <= RESULT_RESET;
			result             <= '{default: RESULT_RESET};
			vsum               <= '{default: '0};
			vcnt               <= '{default: '0};
			temperature_result <= RESULT_RESET;
			tsum               <= '0;
			tcnt               <= '0;
			instant_current    <= RESULT_RESET;
			isum               <= '0;
			icnt               <= '0;
			average_current    <= RESULT_RESET;
			asum               <= '0;
			acnt               <= '0;
			charge_accumulator <= '0;
			o_rdata            <= RESULT_RESET;
		end else begin
			period_cnt         <= next_period_cnt;
			slot               <= next_slot;
			volt_sel           <= next_volt_sel;
			o_conv_req         <= next_conv_req;
			config_word        <= next_config_word;
			result             <= next_result;
			vsum               <= next_vsum;
			vcnt               <= next_vcnt;
			temperature_result <= next_temperature_result;
			tsum               <= next_tsum;
			tcnt               <= next_tcnt;
			instant_current    <= next_instant_current;
			isum               <= next_isum;
			icnt               <= next_icnt;
			average_current    <= next_average_current;
			asum               <= next_asum;
			acnt               <= next_acnt;
			charge_accumulator <= next_charge_accumulator;
			o_rdata            <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// current request timing
	a_cur_req_time: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_conv_req.valid && o_conv_req.chan == CH_CURRENT |-> $past(period_cnt) == 13'h0)
		else $error("current request off period start");
	a_temp_slot: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_conv_req.valid && o_conv_req.chan == CH_TEMP |-> 32'($past(slot)) == TEMP_SLOT)
		else $error("temperature request outside its slot");
	// rounded window mean worked out apart from the datapath, for the check below
	logic signed [16:0] inst_mean;
	assign inst_mean = 17'((isum + 24'(corrected) + 24'sd64) >>> INST_SHIFT);
	a_inst_update: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		cur_valid && icnt == 7'h7f |=> instant_current ==
		(($past(inst_mean) > 17'sd32767) ? POS_LIMIT :
		($past(inst_mean) < -17'sd32768) ? NEG_LIMIT : $past(inst_mean[15:0])))
		else $error("instant current not the rounded 128 sample mean");
	a_inst_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!(cur_valid && icnt == 7'h7f) |=> $stable(instant_current))
		else $error("instant current changed mid window");
	a_acc_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_mem.wr && i_mem.addr == ADDR_ACC_MAIN |=>
		charge_accumulator == {$past(i_mem.wdata), 32'h0})
		else $error("accumulator write did not clear fraction words");
	a_blank_drop: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		cur_valid && blanked && !i_mem.wr |=> $stable(charge_accumulator))
		else $error("blanked sample reached the accumulator");
	a_acc_sat: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		cur_valid && corrected > 17'sd0 && !i_mem.wr &&
		charge_accumulator == {1'b0, {47{1'b1}}} |=> charge_accumulator == {1'b0, {47{1'b1}}})
		else $error("accumulator wrapped on overflow");
	a_cfg_reserved: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_mem.rd && i_mem.addr == ADDR_CONFIG |=> o_rdata[7:1] == 7'h0)
		else $error("reserved configuration bits read nonzero");
	a_read_map: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_mem.rd && i_mem.addr == ADDR_INSTANT |=> o_rdata == $past(instant_current))
		else $error("current word read mismatch");
	a_cfg_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_mem.wr && i_mem.addr == ADDR_CONFIG |=> config_word ==
		{$past(i_mem.wdata[CFG_BIAS_MSB:CFG_BIAS_LSB]), 7'h0, $past(i_mem.wdata[CFG_BLANK_BIT])})
		else $error("configuration write not stored as its fields");
	a_volt_slot: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_conv_req.valid && o_conv_req.chan inside {[CH_LOWER:CH_AUX_RATIO]} |->
		32'($past(slot)) == VOLT_SLOT_A || 32'($past(slot)) == VOLT_SLOT_B)
		else $error("voltage request outside its slots");
	a_req_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_conv_req.valid |=> !o_conv_req.valid)
		else $error("converter request held beyond one cycle");
	a_acc_floor: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		cur_valid && corrected < 17'sd0 && !i_mem.wr &&
		charge_accumulator == {1'b1, 47'h0} |=> charge_accumulator == {1'b1, 47'h0})
		else $error("accumulator wrapped on underflow");
	a_read_main: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_mem.rd && i_mem.addr == ADDR_ACC_MAIN |=>
		o_rdata == $past(charge_accumulator[47:32]))
		else $error("main accumulator word read mismatch");
	a_read_frac: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_mem.rd && i_mem.addr == ADDR_ACC_MID |=>
		o_rdata == $past(charge_accumulator[31:16]))
		else $error("middle accumulator word read mismatch");
	a_rdata_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!i_mem.rd |=> $stable(o_rdata))
		else $error("read data changed without a read");
	a_avg_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!(cur_valid && acnt == 12'hfff) |=> $stable(average_current))
		else $error("average current changed mid window");
	a_temp_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!(i_conv.valid && i_conv.chan == CH_TEMP && tcnt == 5'h1f) |=>
		$stable(temperature_result))
		else $error("temperature result changed mid window");
	a_read_unmapped: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_mem.rd && !(i_mem.addr inside {[ADDR_AUX_RATIO:ADDR_CONFIG]}) |=>
		o_rdata == 16'h0000)
		else $error("unmapped address read nonzero");
endmodule : battery_measurement_results

// ===== tb/tb_top.sv
// self-checking bench for the battery measurement result block
`timescale 1ns/100ps
module tb_top;
	import battery_meas_pkg::*;
	localparam int SP = 16;
	logic         i_ref_clk;
	logic         i_reset_n;
	mem_req_t     mem;
	logic [15:0]  o_rdata;
	conv_req_t    creq;
	conv_result_t conv;
	int           n_errors;
	int           num_checks;
	int           n_cur;
	int           n_volt;
	int           n_temp;
	logic [15:0]  vaddr [1:4];

	battery_measurement_results #(.SAMPLE_PERIOD(SP)) i_battery_measurement_results (
		.i_ref_clk  (i_ref_clk),
		.i_reset_n  (i_reset_n),
		.i_mem      (mem),
		.o_rdata    (o_rdata),
		.o_conv_req (creq),
		.i_conv     (conv)
	);

	// ----------------------------------------------------------------
	// clock and shared tasks
	// ----------------------------------------------------------------
	initial begin
		i_ref_clk = 1'b0;
		forever #50 i_ref_clk = ~i_ref_clk;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop;
		if (n_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge i_ref_clk) #1;
		mem = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge i_ref_clk) #1;
		mem.wr = 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
		@(posedge i_ref_clk) #1;
		mem = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
		@(posedge i_ref_clk) #1;
		mem.rd = 1'b0;
		check($sformatf("word %h", a), o_rdata, exp);
	endtask : rd_chk

	task automatic smp(input conv_chan_t ch, input logic [15:0] d, input int n);
		repeat (n) begin
			@(posedge i_ref_clk) #1;
			conv = '{valid: 1'b1, chan: ch, data: d};
			@(posedge i_ref_clk) #1;
			conv.valid = 1'b0;
		end
	endtask : smp

	task automatic acc_chk(input logic [15:0] m, input logic [15:0] md, input logic [15:0] lo);
		rd_chk(ADDR_ACC_MAIN, m);
		rd_chk(ADDR_ACC_MID, md);
		rd_chk(ADDR_ACC_LOW, lo);
	endtask : acc_chk

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (40000) @(posedge i_ref_clk);
		n_errors++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		n_errors = 0;
		num_checks = 0;
		n_cur = 0;
		n_volt = 0;
		n_temp = 0;
		vaddr = '{ADDR_LOWER, ADDR_UPPER, ADDR_AUX_ABS, ADDR_AUX_RATIO};
		mem = '0;
		conv = '0;
		i_reset_n = 1'b0;
		repeat (4) @(posedge i_ref_clk);
		#1 i_reset_n = 1'b1;
		repeat (10 * SP) begin
			@(posedge i_ref_clk) #1;
			if (creq.valid === 1'b1 && creq.chan === CH_CURRENT) n_cur++;
			if (creq.valid === 1'b1 && creq.chan === CH_TEMP) n_temp++;
			if (creq.valid === 1'b1 && creq.chan inside {[CH_LOWER:CH_AUX_RATIO]}) n_volt++;
		end
		check("current requests", 16'(n_cur), 16'h000a);
		check("voltage requests", 16'(n_volt), 16'h0002);
		check("temperature requests", 16'(n_temp), 16'h0001);
		// reset values, unmapped and read-only places
		wr(ADDR_AVERAGE, 16'habcd);
		for (int a = 0; a < 11; a++) rd_chk(ADDR_AUX_RATIO + 16'(a), RESULT_RESET);
		rd_chk(16'h600b, 16'h0000);
		wr(ADDR_CONFIG, 16'hffff);
		rd_chk(ADDR_CONFIG, 16'hff01);
		wr(ADDR_CONFIG, 16'h0000);
		// long average with three extra bits, clamped
		smp(CH_CURRENT, 16'h1000, 4096);
		rd_chk(ADDR_AVERAGE, POS_LIMIT);
		rd_chk(ADDR_INSTANT, 16'h1000);
		// bias pushes instant result past both limits
		wr(ADDR_CONFIG, 16'h7f00);
		smp(CH_CURRENT, 16'h7fff, 128);
		rd_chk(ADDR_INSTANT, POS_LIMIT);
		wr(ADDR_CONFIG, 16'h8000);
		smp(CH_CURRENT, 16'h8000, 128);
		rd_chk(ADDR_INSTANT, NEG_LIMIT);
		wr(ADDR_CONFIG, 16'h0000);
		smp(CH_CURRENT, 16'hfff0, 128);
		rd_chk(ADDR_INSTANT, 16'hfff0);
		// write clears fraction, bias joins each sample
		wr(ADDR_CONFIG, 16'h0200);
		wr(ADDR_ACC_MAIN, 16'h1234);
		acc_chk(16'h1234, 16'h0000, 16'h0000);
		smp(CH_CURRENT, 16'h0005, 1);
		acc_chk(16'h1234, 16'h0007, 16'h0000);
		wr(ADDR_CONFIG, 16'h0000);
		smp(CH_CURRENT, 16'hfff3, 1);
		acc_chk(16'h1233, 16'hfffa, 16'h0000);
		wr(ADDR_CONFIG, 16'h0001);
		wr(ADDR_ACC_MAIN, 16'h0000);
		smp(CH_CURRENT, 16'h003f, 1);
		acc_chk(16'h0000, 16'h0000, 16'h0000);
		smp(CH_CURRENT, 16'h0040, 1);
		smp(CH_CURRENT, 16'hffff, 1);
		acc_chk(16'h0000, 16'h003f, 16'h0000);
		wr(ADDR_CONFIG, 16'h0000);
		wr(ADDR_ACC_MAIN, 16'h7fff);
		// the fourth sample meets an accumulator that is already full
		smp(CH_CURRENT, 16'h7fff, 4);
		acc_chk(16'h7fff, 16'hffff, 16'hffff);
		acc_chk(16'h7fff, 16'hffff, 16'hffff);
		wr(ADDR_ACC_MAIN, 16'h8000);
		smp(CH_CURRENT, 16'h8000, 1);
		acc_chk(16'h8000, 16'h0000, 16'h0000);
		// voltage words average four samples each
		for (int c = 1; c < 5; c++) begin
			smp(conv_chan_t'(c), 16'h0150 + 16'(c), 4);
			rd_chk(vaddr[c], 16'h0150 + 16'(c));
		end
		smp(CH_LOWER, 16'hffff, 4);
		rd_chk(ADDR_LOWER, POS_LIMIT);
		smp(CH_TEMP, 16'hffe8, 32);
		rd_chk(ADDR_TEMP, 16'hffe8);
		report_and_stop();
	end
endmodule : tb_top
